// *** sas_front_model.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Analog front end: channel levels and comparator
// ****************************************************************
module sas_front_model (
	input  wire logic       clk_i,
	input  wire logic [1:0] chan_sel_i,
	input  wire logic [9:0] dac_code_i,
	input  wire logic       slow_i,
	output logic            comp_o
);
	logic [9:0] level [4];  // Input level per channel, set by the bench
	logic       comp_now;
	logic       comp_dly;

	// unloaded input, level seen as set
	// decision is input at or above trial code
	assign comp_now = (level[chan_sel_i] >= dac_code_i);

	// Slow settling delays the decision one cycle
	always_ff @(posedge clk_i) begin
		comp_dly <= comp_now;
	end
	assign comp_o = slow_i ? comp_dly : comp_now;
endmodule : sas_front_model

// *** sas_pkg.sv ***
// ****************************************************************
// Shared constants for the converter sequencer
// ****************************************************************
package sas_pkg;

	// Timing: clock rate, conversion and sampling times
	localparam int CLK_MHZ        = 25;
	localparam int CONV_TIME_NS   = 12750;
	localparam int SAMPLE_TIME_NS = 7300;
	localparam int SAMPLE_CYCLES  = SAMPLE_TIME_NS * CLK_MHZ / 1000;
	localparam int BIT_CYCLES     = (CONV_TIME_NS - SAMPLE_TIME_NS) * CLK_MHZ / 1000 / 10;
	localparam int SAMPLE_TICKS   = SAMPLE_CYCLES / BIT_CYCLES;

	// Converter geometry
	localparam int RES_BITS   = 10;
	localparam int MAX_CH     = 4;
	localparam int DEF_NUM_CH = 4;
	localparam int ADDR_W     = 18;

	// Register indices (byte address is four times the index)
	localparam logic [15:0] CH0_RESULT_LOW_IDX  = 16'hF2D0;
	localparam logic [15:0] CH0_RESULT_HIGH_IDX = 16'hF2D1;
	localparam logic [15:0] CH1_RESULT_LOW_IDX  = 16'hF2D2;
	localparam logic [15:0] CH1_RESULT_HIGH_IDX = 16'hF2D3;
	localparam logic [15:0] CH2_RESULT_LOW_IDX  = 16'hF2D4;
	localparam logic [15:0] CH2_RESULT_HIGH_IDX = 16'hF2D5;
	localparam logic [15:0] CH3_RESULT_LOW_IDX  = 16'hF2D6;
	localparam logic [15:0] CH3_RESULT_HIGH_IDX = 16'hF2D7;
	localparam logic [15:0] SCAN_MODE_CTRL_IDX  = 16'hF2F0;
	localparam logic [15:0] RUN_CTRL_IDX        = 16'hF2F1;
	localparam logic [15:0] CHANNEL_SELECT_IDX  = 16'hF2F2;
	localparam logic [15:0] BLOCK_CONTROL_4_IDX = 16'hF2F8;
	localparam logic [15:0] RESULT_PAIR_STRIDE  = 16'h0002;

	// Field positions
	localparam int CONT_SCAN_BIT  = 0;
	localparam int RUN_BIT        = 0;
	localparam int BLK_DIS_BIT    = 0;
	localparam int LOW_BYTE_SHIFT = 6;

	// Reset values
	localparam logic [7:0]          CTRL_RST   = 8'h00;
	localparam logic [RES_BITS-1:0] RESULT_RST = 10'h000;

	// Sequencer and approximation engine states
	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_BUSY = 1'b1
	} sas_seq_state_t;

	typedef enum logic [1:0] {
		SAR_IDLE    = 2'b00,
		SAR_SAMPLE  = 2'b01,
		SAR_CONVERT = 2'b10
	} sas_sar_state_t;

endpackage : sas_pkg

// *** sas_sar_engine.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Sample phase and ten-step approximation of one channel
// ****************************************************************
module sas_sar_engine #(
	parameter int SAMPLE_TICKS = sas_pkg::SAMPLE_TICKS
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic                         start_i,
	input  wire logic                         abort_i,
	input  wire logic                         tick_i,
	input  wire logic                         comp_i,
	output logic                              busy_o,
	output logic                              done_o,
	output logic                              sample_o,
	output logic [sas_pkg::RES_BITS-1:0]      result_o,
	output logic [sas_pkg::RES_BITS-1:0]      dac_code_o
);
	localparam int SW = (SAMPLE_TICKS > 1) ? $clog2(SAMPLE_TICKS) : 1;

	sas_pkg::sas_sar_state_t     state_reg;
	logic [SW-1:0]               smp_cnt_reg;
	logic [3:0]                  bit_reg;
	logic [sas_pkg::RES_BITS-1:0] judged;

	// Keep the trial bit when the input is at or above the trial level
	always_comb begin
		judged = comp_i ? dac_code_o : (dac_code_o & ~(10'h001 << bit_reg));
	end

	// Busy while sampling or converting; sample level is a flop
	assign busy_o   = (state_reg != sas_pkg::SAR_IDLE);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || abort_i) begin
			state_reg   <= sas_pkg::SAR_IDLE;
			smp_cnt_reg <= '0;
			bit_reg     <= 4'h0;
			dac_code_o  <= sas_pkg::RESULT_RST;
			done_o      <= 1'b0;
			result_o    <= sas_pkg::RESULT_RST;
			sample_o    <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_reg)
				sas_pkg::SAR_IDLE: begin
					if (start_i) begin
						state_reg   <= sas_pkg::SAR_SAMPLE;
						sample_o    <= 1'b1;
						smp_cnt_reg <= '0;
						dac_code_o  <= sas_pkg::RESULT_RST;
					end
				end
				sas_pkg::SAR_SAMPLE: begin
					if (tick_i) begin
						if (smp_cnt_reg == SW'(SAMPLE_TICKS - 1)) begin
							state_reg  <= sas_pkg::SAR_CONVERT;
							sample_o   <= 1'b0;
							bit_reg    <= 4'h9;
							dac_code_o <= 10'h200;
						end else begin
							smp_cnt_reg <= smp_cnt_reg + 1'b1;
						end
					end
				end
				sas_pkg::SAR_CONVERT: begin
					if (tick_i) begin
						if (bit_reg == 4'h0) begin
							result_o   <= judged;
							dac_code_o <= judged;
							done_o     <= 1'b1;
							state_reg  <= sas_pkg::SAR_IDLE;
						end else begin
							bit_reg    <= bit_reg - 1'b1;
							dac_code_o <= judged | (10'h001 << (bit_reg - 1'b1));
						end
					end
				end
				default: begin
					state_reg <= sas_pkg::SAR_IDLE;
					sample_o  <= 1'b0;
				end
			endcase
		end
	end
endmodule : sas_sar_engine

// *** sas_sequencer.sv ***
// Local design decision: the APB register port.
`timescale 1ns/10ps
// ****************************************************************
// Multi-channel successive-approximation converter sequencer
// ****************************************************************
module sas_sequencer #(
	parameter int NUM_CH = sas_pkg::DEF_NUM_CH
) (
	input  wire logic                          SYS_CLK_I,
	input  wire logic                          RST_N_I,
	input  wire logic                          PSEL_I,
	input  wire logic                          PENABLE_I,
	input  wire logic                          PWRITE_I,
	input  wire logic [sas_pkg::ADDR_W-1:0]    PADDR_I,
	input  wire logic [31:0]                   PWDATA_I,
	input  wire logic [3:0]                    PSTRB_I,
	output logic      [31:0]                   PRDATA_O,
	output logic                               PREADY_O,
	output logic                               PSLVERR_O,
	input  wire logic                          HS_CLK_EN_I,
	input  wire logic                          COMP_I,
	output logic                               SAMPLE_O,
	output logic      [sas_pkg::RES_BITS-1:0]  DAC_CODE_O,
	output logic      [1:0]                    CHAN_SEL_O,
	output logic                               CONV_END_IRQ_O
);
	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Lowest set bit of a channel mask, found flag on top
	function automatic logic [2:0] sas_first_set(input logic [3:0] mask);
		logic [2:0] res;
		res = 3'h0;
		for (int i = sas_pkg::MAX_CH - 1; i >= 0; i--) begin
			if (mask[i]) begin
				res = {1'b1, 2'(i)};
			end
		end
		return res;
	endfunction : sas_first_set

	// Register index of a channel's low result byte
	function automatic logic [15:0] sas_low_idx(input int ch);
		return 16'(sas_pkg::CH0_RESULT_LOW_IDX + sas_pkg::RESULT_PAIR_STRIDE * 16'(ch));
	endfunction : sas_low_idx

	// Select bits that exist in this build
	localparam logic [3:0] CH_MASK = 4'((1 << NUM_CH) - 1);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic                          comp_s1_reg;
	logic                          comp_s2_reg;
	logic                          hs_s1_reg;
	logic                          hs_s2_reg;
	logic                          blk_disable_reg;
	logic                          blk_rst;
	logic                          scan_mode_reg;
	logic                          run_reg;
	logic [3:0]                    chan_sel_reg;
	logic [3:0]                    latched_sel_reg;
	logic [1:0]                    cur_ch_reg;
	logic                          start_reg;
	logic [sas_pkg::RES_BITS-1:0]  result_reg [sas_pkg::MAX_CH];
	sas_pkg::sas_seq_state_t       state_reg;
	logic [15:0]                   idx;
	logic                          addr_hit;
	logic                          addr_ro;
	logic [31:0]                   rd_data;
	logic                          acc_err;
	logic                          wr_fire;
	logic                          run_wr;
	logic                          run_wr_val;
	logic                          stop_now;
	logic [2:0]                    first_pick;
	logic [2:0]                    next_pick;
	logic                          sar_busy;
	logic                          sar_done;
	logic [sas_pkg::RES_BITS-1:0]  sar_result;
	logic                          tick;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************

	// Comparator and clock-enable pins, two flops each
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			comp_s1_reg <= 1'b0;
			comp_s2_reg <= 1'b0;
			hs_s1_reg   <= 1'b0;
			hs_s2_reg   <= 1'b0;
		end else begin
			comp_s1_reg <= COMP_I;
			comp_s2_reg <= comp_s1_reg;
			hs_s1_reg   <= HS_CLK_EN_I;
			hs_s2_reg   <= hs_s1_reg;
		end
	end

	assign blk_rst = !RST_N_I || blk_disable_reg;

	// ****************************************************************
	// APB slave
	// ****************************************************************
	// Word index, low two address bits checked for alignment
	assign idx = PADDR_I[sas_pkg::ADDR_W-1:2];

	// Read mux and address decode
	always_comb begin
		rd_data  = 32'h0000_0000;
		addr_hit = 1'b0;
		addr_ro  = 1'b0;
		for (int c = 0; c < NUM_CH; c++) begin
			// low byte, pair readable as 16 bits
			if (idx == sas_low_idx(c)) begin
				addr_hit = 1'b1;
				addr_ro  = 1'b1;
				rd_data  = {16'h0000, result_reg[c][9:2], result_reg[c][1:0], 6'h00};
			end
			if (idx == 16'(sas_low_idx(c) + 16'h0001)) begin
				addr_hit = 1'b1;
				addr_ro  = 1'b1;
				rd_data  = {24'h000000, result_reg[c][9:2]};
			end
		end
		case (idx)
			sas_pkg::SCAN_MODE_CTRL_IDX: begin
				addr_hit = 1'b1;
				rd_data  = {16'h0000, 7'h00, run_reg, 7'h00, scan_mode_reg};
			end
			sas_pkg::RUN_CTRL_IDX: begin
				addr_hit = 1'b1;
				rd_data  = {24'h000000, 7'h00, run_reg};
			end
			sas_pkg::CHANNEL_SELECT_IDX: begin
				addr_hit = 1'b1;
				rd_data  = {24'h000000, 4'h0, chan_sel_reg};
			end
			sas_pkg::BLOCK_CONTROL_4_IDX: begin
				addr_hit = 1'b1;
				rd_data  = {24'h000000, 7'h00, blk_disable_reg};
			end
			default: begin
				// Unmapped index reads zero
			end
		endcase
	end

	// Unmapped, misaligned, or write to read-only word
	assign acc_err = !addr_hit || (PADDR_I[1:0] != 2'b00) || (PWRITE_I && addr_ro);

	// Write commits at the edge where ready is seen high
	assign wr_fire = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !acc_err;

	// One wait state, then ready with registered data
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			PREADY_O  <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O  <= PSEL_I && PENABLE_I && !PREADY_O;
			PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && acc_err;
			if (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I && !acc_err) begin
				PRDATA_O <= rd_data;
			end else begin
				PRDATA_O <= 32'h0000_0000;
			end
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************

	// Block disable, reset only by the system reset
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			blk_disable_reg <= 1'b0;
		end else if (wr_fire && idx == sas_pkg::BLOCK_CONTROL_4_IDX && PSTRB_I[0]) begin
			blk_disable_reg <= PWDATA_I[sas_pkg::BLK_DIS_BIT];
		end
	end

	// scan mode and channel select, zero reset
	always_ff @(posedge SYS_CLK_I) begin
		if (blk_rst) begin
			scan_mode_reg <= sas_pkg::CTRL_RST[0];
			chan_sel_reg  <= sas_pkg::CTRL_RST[3:0];
		end else if (wr_fire && PSTRB_I[0]) begin
			if (idx == sas_pkg::SCAN_MODE_CTRL_IDX) begin
				scan_mode_reg <= PWDATA_I[sas_pkg::CONT_SCAN_BIT];
			end
			if (idx == sas_pkg::CHANNEL_SELECT_IDX) begin
				chan_sel_reg <= PWDATA_I[3:0] & CH_MASK;
			end
		end
	end

	// Run bit written by byte or by 16-bit control access
	assign run_wr = wr_fire && ((idx == sas_pkg::RUN_CTRL_IDX && PSTRB_I[0])
		|| (idx == sas_pkg::SCAN_MODE_CTRL_IDX && PSTRB_I[1]));
	assign run_wr_val = (idx == sas_pkg::RUN_CTRL_IDX) ? PWDATA_I[sas_pkg::RUN_BIT]
		: PWDATA_I[8 + sas_pkg::RUN_BIT];
	assign stop_now = run_wr && !run_wr_val;

	// ****************************************************************
	// Channel sequencing
	// ****************************************************************

	// lowest channel first, next one above current
	assign first_pick = sas_first_set(chan_sel_reg);
	assign next_pick  = sas_first_set(latched_sel_reg & (4'hE << cur_ch_reg));

	// Scan state, run bit, latched selection
	always_ff @(posedge SYS_CLK_I) begin
		if (blk_rst) begin
			state_reg       <= sas_pkg::SEQ_IDLE;
			run_reg         <= 1'b0;
			latched_sel_reg <= 4'h0;
			cur_ch_reg      <= 2'h0;
			start_reg       <= 1'b0;
			CONV_END_IRQ_O  <= 1'b0;
		end else begin
			// Strobes default low, raised for one cycle
			start_reg      <= 1'b0;
			CONV_END_IRQ_O <= 1'b0;
			if (stop_now) begin
				// stop aborts and returns to idle
				run_reg   <= 1'b0;
				state_reg <= sas_pkg::SEQ_IDLE;
			end else if (run_wr && state_reg == sas_pkg::SEQ_IDLE) begin
				// start refused without a selected channel
				if (first_pick[2]) begin
					run_reg         <= 1'b1;
					latched_sel_reg <= chan_sel_reg;
					cur_ch_reg      <= first_pick[1:0];
					start_reg       <= 1'b1;
					state_reg       <= sas_pkg::SEQ_BUSY;
				end
			end else if (state_reg == sas_pkg::SEQ_BUSY && sar_done) begin
				if (next_pick[2]) begin
					cur_ch_reg <= next_pick[1:0];
					start_reg  <= 1'b1;
				end else begin
					CONV_END_IRQ_O <= 1'b1;
					if (scan_mode_reg && first_pick[2]) begin
						latched_sel_reg <= chan_sel_reg;
						cur_ch_reg      <= first_pick[1:0];
						start_reg       <= 1'b1;
					end else begin
						run_reg   <= 1'b0;
						state_reg <= sas_pkg::SEQ_IDLE;
					end
				end
			end
		end
	end

	// ****************************************************************
	// Result storage
	// ****************************************************************

	// only the finished channel is written
	always_ff @(posedge SYS_CLK_I) begin
		if (blk_rst) begin
			for (int c = 0; c < sas_pkg::MAX_CH; c++) begin
				result_reg[c] <= sas_pkg::RESULT_RST;
			end
		end else if (state_reg == sas_pkg::SEQ_BUSY && sar_done && !stop_now) begin
			result_reg[cur_ch_reg] <= sar_result;
		end
	end

	// Analog mux select follows the channel in conversion
	assign CHAN_SEL_O = cur_ch_reg;

	// ****************************************************************
	// Conversion engine and step timing
	// ****************************************************************

	// steps only while high-speed clock runs
	sas_tick_div #(
		.DIV (sas_pkg::BIT_CYCLES)
	) u_tick (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (!blk_rst),
		.en_i    (sar_busy && hs_s2_reg),
		.tick_o  (tick)
	);

	sas_sar_engine #(
		.SAMPLE_TICKS (sas_pkg::SAMPLE_TICKS)
	) u_sar (
		.clk_i      (SYS_CLK_I),
		.rst_n_i    (!blk_rst),
		.start_i    (start_reg),
		.abort_i    (stop_now),
		.tick_i     (tick),
		.comp_i     (comp_s2_reg),
		.busy_o     (sar_busy),
		.done_o     (sar_done),
		.sample_o   (SAMPLE_O),
		.result_o   (sar_result),
		.dac_code_o (DAC_CODE_O)
	);

endmodule : sas_sequencer

// *** sas_sequencer_props.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Port-level checks of the converter sequencer
// ****************************************************************
module sas_sequencer_props (
	input wire logic                         SYS_CLK_I,
	input wire logic                         RST_N_I,
	input wire logic                         PSEL_I,
	input wire logic                         PENABLE_I,
	input wire logic [31:0]                  PRDATA_O,
	input wire logic                         PREADY_O,
	input wire logic                         PSLVERR_O,
	input wire logic                         SAMPLE_O,
	input wire logic [sas_pkg::RES_BITS-1:0] DAC_CODE_O,
	input wire logic [1:0]                   CHAN_SEL_O,
	input wire logic                         CONV_END_IRQ_O
);
	logic [8:0] high_cnt;  // Cycles of the running sample phase
	logic [8:0] gap_cnt;   // Cycles since the sample phase ended
	logic [1:0] last_ch;
	logic       pass_open;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	// Phase length counters
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			high_cnt <= 9'h000;
			gap_cnt  <= 9'h1FF;
		end else begin
			high_cnt <= SAMPLE_O ? high_cnt + 9'h001 : 9'h000;
			gap_cnt  <= SAMPLE_O ? 9'h000 : ((gap_cnt == 9'h1FF) ? gap_cnt : gap_cnt + 9'h001);
		end
	end

	// Last channel sampled within the current pass
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			pass_open <= 1'b0;
			last_ch   <= 2'h0;
		end else if (CONV_END_IRQ_O) begin
			pass_open <= 1'b0;
		end else if (SAMPLE_O) begin
			pass_open <= 1'b1;
			last_ch   <= CHAN_SEL_O;
		end
	end

	sequence access_s;
		PSEL_I && $rose(PENABLE_I);
	endsequence
	sequence first_trial_s;
		##[0:2] (DAC_CODE_O == 10'h200);
	endsequence

	ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready held longer than one cycle");
	ready_wait_a: assert property (access_s |=> PREADY_O)
		else $error("ready not given one cycle into access");
	rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0000_0000)
		else $error("read data driven outside ready");
	err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error flag without ready");
	sample_len_a: assert property ($fell(SAMPLE_O) |-> high_cnt >= 176 && high_cnt <= 190)
		else $error("sample phase length off");
	first_trial_a: assert property ($fell(SAMPLE_O) |-> first_trial_s)
		else $error("first trial code not midscale");
	chan_order_a: assert property ($rose(SAMPLE_O) && pass_open && gap_cnt < 160 |-> CHAN_SEL_O > last_ch)
		else $error("channels not ascending within a pass");
	irq_timing_a: assert property (CONV_END_IRQ_O |-> !SAMPLE_O && gap_cnt >= 120 && gap_cnt <= 145)
		else $error("end pulse not after ten steps");
	irq_pulse_a: assert property (CONV_END_IRQ_O |=> !CONV_END_IRQ_O)
		else $error("end pulse longer than one cycle");
	chan_hold_a: assert property (SAMPLE_O && $past(SAMPLE_O) |-> $stable(CHAN_SEL_O))
		else $error("channel changed during sampling");
endmodule : sas_sequencer_props

// *** sas_sequencer_tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("FAIL %s exp %h got %h", nm, e, g); end end
// ****************************************************************
// Self-checking bench for the converter sequencer
// ****************************************************************
module sas_sequencer_tb;
	localparam logic [15:0] R0   = sas_pkg::CH0_RESULT_LOW_IDX;
	localparam logic [15:0] SCAN = sas_pkg::SCAN_MODE_CTRL_IDX;
	localparam logic [15:0] RUN  = sas_pkg::RUN_CTRL_IDX;
	localparam logic [15:0] SEL  = sas_pkg::CHANNEL_SELECT_IDX;
	localparam logic [15:0] BLK  = sas_pkg::BLOCK_CONTROL_4_IDX;
	logic                        sys_clk = 1'b0;
	logic                        rst_n   = 1'b0;
	logic                        psel    = 1'b0;
	logic                        penable = 1'b0;
	logic                        pwrite  = 1'b0;
	logic [sas_pkg::ADDR_W-1:0]  paddr   = '0;
	logic [31:0]                 pwdata  = 32'h0000_0000;
	logic [3:0]                  pstrb   = 4'h0;
	logic                        slow    = 1'b0;
	logic                        hs_en   = 1'b0;
	logic                        pslverr3, err3;
	logic                        comp, pready, pslverr, sample, irq, err, samp_q;
	logic [31:0]                 prdata, rd, prdata3, rd3;
	logic [sas_pkg::RES_BITS-1:0] dac;
	logic [1:0]                  chan;
	logic [1:0]                  order [$];
	int                          n_fail = 0;
	int                          check_count = 0;
	int                          cyc = 0;
	int                          irq_cnt = 0;
	int                          t0, n_irq;

	sas_sequencer #(.NUM_CH(4)) dut (
		.SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .HS_CLK_EN_I(hs_en), .COMP_I(comp), .SAMPLE_O(sample), .DAC_CODE_O(dac),
		.CHAN_SEL_O(chan), .CONV_END_IRQ_O(irq)
	);
	// Three-channel build on the same bus, only its read path is checked
	sas_sequencer #(.NUM_CH(3)) dut3 (
		.SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata3), .PREADY_O(),
		.PSLVERR_O(pslverr3), .HS_CLK_EN_I(hs_en), .COMP_I(comp), .SAMPLE_O(), .DAC_CODE_O(),
		.CHAN_SEL_O(), .CONV_END_IRQ_O()
	);
	sas_front_model fm (.clk_i(sys_clk), .chan_sel_i(chan), .dac_code_i(dac), .slow_i(slow), .comp_o(comp));

	// Clock and cycle ceiling
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	// Channel order at each new sample phase, end pulse count
	always @(posedge sys_clk) begin
		if (sample === 1'b1 && samp_q !== 1'b1) order.push_back(chan);
		if (irq === 1'b1) irq_cnt++;
		samp_q = sample;
	end

	// One bus transfer, entered just after a clock edge
	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic [3:0] st);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= {idx, 2'b00};
		pwdata <= d;
		pstrb  <= st;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		rd3 = prdata3;
		err3 = pslverr3;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, 4'h1);
	endtask : wr

	task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 32'h0000_0000, 4'h0);
		`CHK(nm, e, rd)
	endtask : rdc

	// Bounded wait for the end pulse (s=0) or a sample level (s=1)
	task automatic wait_for(input logic s, input logic v, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while ((s ? sample : irq) !== v && n < lim);
		if ((s ? sample : irq) !== v) n_fail++;
	endtask : wait_for

	function automatic logic [31:0] res_word(input logic [9:0] v);
		return {16'h0000, v[9:2], v[1:0], 6'h00};
	endfunction : res_word

	task automatic results;
		if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// Main sequence
	initial begin
		fm.level[0] = 10'h2C7;
		fm.level[1] = 10'h155;
		fm.level[2] = 10'h0FE;
		fm.level[3] = 10'h001;
		repeat (8) @(posedge sys_clk);
		hs_en <= 1'b1;
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 8; i++) rdc("result_rst", R0 + 16'(i), 32'h0);
		`CHK("ch3_absent", 1'b1, err3)
		for (int i = 0; i < 3; i++) rdc("ctrl_rst", SCAN + 16'(i), 32'h0);
		apb(1'b1, R0, 32'hFFFF_FFFF, 4'hF);
		`CHK("ro_err", 1'b1, err)
		rdc("ro_keep", R0, 32'h0);
		apb(1'b0, 16'hF2E0, 32'h0, 4'h0);
		`CHK("unmapped_err", 1'b1, err)
		wr(SEL, 32'hFF);
		rdc("sel_mask", SEL, 32'hF);
		`CHK("sel_3ch", 32'h7, rd3)
		wr(SEL, 32'h0);
		wr(RUN, 32'h1);
		rdc("run_empty", RUN, 32'h0);
		// Single pass over channels 0 and 2, selection changed meanwhile
		wr(SEL, 32'h5);
		wr(SCAN, 32'h0);
		wr(RUN, 32'h1);
		t0 = cyc;
		wr(SEL, 32'h2);
		wait_for(1'b0, 1'b1, 1000);
		`CHK("pass_time", 1'b1, (cyc - t0) inside {[600:660]})
		`CHK("order_len", 32'd2, 32'(order.size()))
		`CHK("order_1st", 2'd0, order[0])
		`CHK("order_2nd", 2'd2, order[1])
		rdc("ch0", R0, res_word(fm.level[0]));
		rdc("ch1_keep", R0 + 16'h2, 32'h0);
		rdc("ch2_high", R0 + 16'h5, {24'h0, fm.level[2][9:2]});
		rdc("run_done", RUN, 32'h0);
		// Continuous scan of channel 3: mode first, then one 16-bit write
		wr(SEL, 32'h8);
		wr(SCAN, 32'h1);
		slow <= 1'b1;
		apb(1'b1, SCAN, 32'h0000_0101, 4'h3);
		wait_for(1'b0, 1'b1, 400);
		rdc("ch3_first", R0 + 16'h6, res_word(10'h001));
		fm.level[3] = 10'h3FE;
		wait_for(1'b0, 1'b1, 400);
		rdc("ch3_again", R0 + 16'h6, res_word(10'h3FE));
		rdc("scan_run", SCAN, 32'h0000_0101);
		// Clock pause freezes the steps, then stop in mid conversion
		fm.level[3] = 10'h2AA;
		wait_for(1'b1, 1'b1, 400);
		wait_for(1'b1, 1'b0, 400);
		repeat (20) @(posedge sys_clk);
		n_irq = irq_cnt;
		hs_en <= 1'b0;
		repeat (200) @(posedge sys_clk);
		`CHK("hs_pause", n_irq, irq_cnt)
		hs_en <= 1'b1;
		wr(RUN, 32'h0);
		repeat (400) @(posedge sys_clk);
		`CHK("abort_irq", n_irq, irq_cnt)
		`CHK("abort_idle", 1'b0, sample)
		rdc("abort_keep", R0 + 16'h6, res_word(10'h3FE));
		// Block disable holds control and result registers in reset
		wr(BLK, 32'h1);
		wr(SEL, 32'hF);
		wr(RUN, 32'h1);
		rdc("dis_sel", SEL, 32'h0);
		rdc("dis_run", RUN, 32'h0);
		rdc("dis_res", R0 + 16'h6, 32'h0);
		wr(BLK, 32'h0);
		rdc("en_res", R0 + 16'h7, 32'h0);
		results();
	end
endmodule : sas_sequencer_tb

bind sas_sequencer sas_sequencer_props props_u (
	.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SAMPLE_O(SAMPLE_O), .DAC_CODE_O(DAC_CODE_O),
	.CHAN_SEL_O(CHAN_SEL_O), .CONV_END_IRQ_O(CONV_END_IRQ_O)
);

// *** sas_tick_div.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Bit-step enable divider
// ****************************************************************
module sas_tick_div #(
	parameter int DIV = sas_pkg::BIT_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic en_i,
	output logic      tick_o
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [CW-1:0] cnt_reg;

	// Count while enabled, one-cycle pulse every DIV cycles
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !en_i) begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
		end else if (cnt_reg == CW'(DIV - 1)) begin
			cnt_reg <= '0;
			tick_o  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick_o  <= 1'b0;
		end
	end
endmodule : sas_tick_div
